// ==== logic/e1ram_pkg.sv ====
// Constants, register map and carrier types for the E1 receive alarm block.
// Assumes one 10 MHz reference clock and a plain register port.
// Notes on behaviour
// RULE1 - Eight receive channels, each fully independent of the others.
// RULE2 - Hardware mode: code select low picks HDB3, high picks AMI.
// RULE3 - Termination 00/01: Rx high-Z, 10/11: Rx on; odd picks 120 ohm.
// RULE4 - Recovered clock keeps running from the reference when no signal.
// RULE5 - Data change on rising recovered clock edge, falling when invert set.
// RULE6 - Loss and all-ones alarms each have their own interrupt mask.
// RULE7 - No interrupt unless the global interrupt enable bit is set.
// RULE8 - Change of an enabled unmasked alarm pulls the interrupt low.
// RULE9 - Reading status clears it, then the interrupt releases.
// RULE10 - Interrupt output only pulls low or floats, never drives high.
// RULE11 - G.775: declare loss after 32 periods below the low threshold.
// RULE12 - G.775: clear loss on high level, 12.5% ones, at most 15 zeros.
// RULE13 - ETSI: declare loss after more than 2048 periods below threshold.
// RULE14 - ETSI: clear loss after over 32 good periods at 12.5% density.
// RULE15 - ETSI loss scheme only in host mode; hardware mode uses G.775.
// RULE16 - All-ones flag reads 1 on detection; standard chosen per channel.
// RULE17 - G.775: set all-ones when two or fewer zeros in 512 bits.
// RULE18 - G.775: clear all-ones on three or more zeros in 512 bits.
// RULE19 - ETSI: all-ones whenever fewer than three zeros in 512-bit window.
// RULE20 - ETSI all-ones scheme only in host mode.
// RULE21 - Slicer threshold inputs sampled per recovered bit period.
// RULE22 - Interrupt is OR of latched unmasked changes, gated by enable.
package e1ram_pkg;
	localparam int CH_COUNT = 8;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int LANE = 8;

	// Register byte offsets
	localparam logic [7:0] OFS_GLOBAL = 8'h00;
	localparam logic [7:0] OFS_CH_CFG = 8'h04;
	localparam logic [7:0] OFS_ALARM = 8'h08;
	localparam logic [7:0] OFS_STATUS = 8'h0C;

	// Global register fields
	localparam int GLB_IRQ_EN_BIT = 0;
	localparam int GLB_CLK_INV_BIT = 1;
	localparam int GLB_TERM_LSB = 2;
	// Channel config lanes: AMI select, ETSI select, loss mask, all-ones mask
	localparam int CFG_AMI_LSB = 0;
	localparam int CFG_ETSI_LSB = 8;
	localparam int CFG_LOS_MASK_LSB = 16;
	localparam int CFG_AIS_MASK_LSB = 24;
	// Alarm and status lanes
	localparam int ST_LOS_LSB = 0;
	localparam int ST_AIS_LSB = 8;

	localparam logic [31:0] RST_GLOBAL = 32'h0000_0000;
	localparam logic [31:0] RST_CH_CFG = 32'h0000_0000;

	// Bit clock synthesis
	localparam longint CLK_HZ = 10000000;
	localparam longint BIT_HZ = 2048000;
	localparam int NCO_W = 16;
	localparam logic [15:0] NCO_INC =
		16'((BIT_HZ * (64'd1 << NCO_W)) / CLK_HZ);
	localparam logic [15:0] NCO_ON_PULSE = 16'h8000;

	// Alarm counts in bit periods
	localparam logic [11:0] LOS_G775_SET = 12'h020;
	localparam logic [11:0] LOS_ETSI_SET = 12'h801;
	localparam logic [5:0] LOS_WIN_ONES = 6'h04;
	localparam logic [4:0] LOS_ZERO_LIMIT = 5'h10;
	localparam logic [5:0] LOS_WIN_LEN = 6'h20;
	localparam logic [5:0] LOS_ETSI_GOOD = 6'h21;
	localparam logic [7:0] AIS_HALF_LAST = 8'hFF;
	localparam logic [2:0] AIS_ZERO_MIN = 3'h3;

	typedef struct packed {
		logic irq_en;
		logic clk_inv;
		logic [1:0] term_sel;
	} e1ram_glb_s;

	typedef struct packed {
		logic tx_120;
		logic rx_on;
		logic rx_120;
	} e1ram_term_s;
endpackage

// ==== logic/e1ram_sync3.sv ====
// Three-stage input synchroniser with agreement filter.
// Assumes asynchronous pins; output moves once stages two and three agree.
`timescale 1ns/1ns
module e1ram_sync3 #(
	parameter int W = 1
) (
	input wire logic i_ref_clk,
	input wire logic i_rstn,
	input wire logic [W-1:0] i_async,
	output logic [W-1:0] o_level
);
	logic [W-1:0] stage1;
	logic [W-1:0] stage2;
	logic [W-1:0] stage3;

	always_ff @(posedge i_ref_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			stage1 <= '0;
			stage2 <= '0;
			stage3 <= '0;
		end else begin
			stage1 <= i_async;
			stage2 <= stage1;
			stage3 <= stage2;
		end
	end

	// Take a bit only when the two settled stages agree
	always_ff @(posedge i_ref_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			o_level <= '0;
		end else begin
			o_level <= (stage2 & stage3) | (o_level & (stage2 | stage3));
		end
	end
endmodule

// ==== logic/e1ram_top.sv ====
// E1 receive side: bit clock, line decode, loss and all-ones alarms.
// Assumes slicer pulses and threshold levels arrive as async digital pins.
//
// Decided for this implementation: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ns
module e1ram_top import e1ram_pkg::*; #(
	parameter int N_CH = CH_COUNT
) (
	input wire logic i_ref_clk,
	input wire logic i_rstn,
	input wire logic i_hw_mode,
	input wire logic [N_CH-1:0] i_rx_line_a,
	input wire logic [N_CH-1:0] i_rx_line_b,
	input wire logic [N_CH-1:0] i_above_high,
	input wire logic [N_CH-1:0] i_below_low,
	input wire logic [N_CH-1:0] i_neg_data_or_code_select,
	input wire logic [1:0] i_termination_select,
	input wire logic [ADDR_W-1:0] i_addr,
	input wire logic [DATA_W-1:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [DATA_W-1:0] o_rdata,
	output logic [N_CH-1:0] o_rx_clk,
	output logic [N_CH-1:0] o_rx_pos_data,
	output logic [N_CH-1:0] o_rx_neg_data,
	output logic [N_CH-1:0] o_rx_signal_loss,
	output logic [N_CH-1:0] o_all_ones_alarm,
	output logic o_irq_n_out,
	output logic o_irq_n_oe,
	output logic o_term_tx_120,
	output logic o_term_rx_on,
	output logic o_term_rx_120
);
	if (N_CH < 1 || N_CH > LANE) begin : g_bad_ch
		$error("e1ram_top: channel count must be 1 to 8");
	end

	localparam int SYNC_W = 5 * N_CH + 3;

	function automatic logic [5:0] count_ones(input logic [31:0] v);
		logic [5:0] n;
		n = '0;
		for (int k = 0; k < 32; k++) begin
			n = n + {5'b0, v[k]};
		end
		return n;
	endfunction

	function automatic e1ram_term_s term_decode(input logic [1:0] sel);
		e1ram_term_s t;
		t.tx_120 = sel[0];
		t.rx_on = sel[1];
		t.rx_120 = sel[1] & sel[0];
		return t;
	endfunction

	function automatic logic hit(input logic [ADDR_W-1:0] a,
		input logic [7:0] ofs);
		return a == ofs;
	endfunction

	// Pin synchronisers
	logic [SYNC_W-1:0] pins;
	logic [N_CH-1:0] line_a;
	logic [N_CH-1:0] line_b;
	logic [N_CH-1:0] above;
	logic [N_CH-1:0] below;
	logic [N_CH-1:0] code_pin;
	logic hw_mode;
	logic [1:0] term_pin;

	e1ram_sync3 #(
		.W(SYNC_W)
	) u_sync (
		.i_ref_clk(i_ref_clk),
		.i_rstn(i_rstn),
		.i_async({i_hw_mode, i_termination_select, i_neg_data_or_code_select,
			i_below_low, i_above_high, i_rx_line_b, i_rx_line_a}),
		.o_level(pins)
	);

	assign line_a = pins[N_CH-1:0];
	assign line_b = pins[2*N_CH-1:N_CH];
	assign above = pins[3*N_CH-1:2*N_CH];
	assign below = pins[4*N_CH-1:3*N_CH];
	assign code_pin = pins[5*N_CH-1:4*N_CH];
	assign term_pin = pins[5*N_CH+1:5*N_CH];
	assign hw_mode = pins[5*N_CH+2];

	// Software registers
	e1ram_glb_s glb;
	logic [N_CH-1:0] reg_ami;
	logic [N_CH-1:0] reg_etsi;
	logic [N_CH-1:0] mask_los;
	logic [N_CH-1:0] mask_ais;
	logic [N_CH-1:0] chg_los;
	logic [N_CH-1:0] chg_ais;
	logic [N_CH-1:0] ev_los;
	logic [N_CH-1:0] ev_ais;
	logic status_rd;

	always_ff @(posedge i_ref_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			glb <= e1ram_glb_s'(RST_GLOBAL[3:0]);
		end else if (i_wr && hit(i_addr, OFS_GLOBAL)) begin
			glb.irq_en <= i_wdata[GLB_IRQ_EN_BIT];
			glb.clk_inv <= i_wdata[GLB_CLK_INV_BIT];
			glb.term_sel <= i_wdata[GLB_TERM_LSB +: 2];
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			reg_ami <= RST_CH_CFG[CFG_AMI_LSB +: N_CH];
			reg_etsi <= RST_CH_CFG[CFG_ETSI_LSB +: N_CH];
			mask_los <= RST_CH_CFG[CFG_LOS_MASK_LSB +: N_CH];
			mask_ais <= RST_CH_CFG[CFG_AIS_MASK_LSB +: N_CH];
		end else if (i_wr && hit(i_addr, OFS_CH_CFG)) begin
			reg_ami <= i_wdata[CFG_AMI_LSB +: N_CH];
			reg_etsi <= i_wdata[CFG_ETSI_LSB +: N_CH];
			mask_los <= i_wdata[CFG_LOS_MASK_LSB +: N_CH];
			mask_ais <= i_wdata[CFG_AIS_MASK_LSB +: N_CH];
		end
	end

	// Read data, one cycle after the strobe
	always_ff @(posedge i_ref_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			o_rdata <= '0;
		end else begin
			o_rdata <= '0;
			if (i_rd) begin
				case (i_addr)
					OFS_GLOBAL: begin
						o_rdata[GLB_IRQ_EN_BIT] <= glb.irq_en;
						o_rdata[GLB_CLK_INV_BIT] <= glb.clk_inv;
						o_rdata[GLB_TERM_LSB +: 2] <= glb.term_sel;
					end
					OFS_CH_CFG: begin
						o_rdata[CFG_AMI_LSB +: N_CH] <= reg_ami;
						o_rdata[CFG_ETSI_LSB +: N_CH] <= reg_etsi;
						o_rdata[CFG_LOS_MASK_LSB +: N_CH] <= mask_los;
						o_rdata[CFG_AIS_MASK_LSB +: N_CH] <= mask_ais;
					end
					OFS_ALARM: begin
						o_rdata[ST_LOS_LSB +: N_CH] <= o_rx_signal_loss; // RULE16
						o_rdata[ST_AIS_LSB +: N_CH] <= o_all_ones_alarm;
					end
					OFS_STATUS: begin
						o_rdata[ST_LOS_LSB +: N_CH] <= chg_los;
						o_rdata[ST_AIS_LSB +: N_CH] <= chg_ais;
					end
					default: begin
						o_rdata <= '0;
					end
				endcase
			end
		end
	end

	// Change latches clear on read; a new change in that cycle survives
	assign status_rd = i_rd && hit(i_addr, OFS_STATUS);

	always_ff @(posedge i_ref_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			chg_los <= '0;
			chg_ais <= '0;
		end else begin
			chg_los <= ev_los | (chg_los & {N_CH{!status_rd}}); // RULE9
			chg_ais <= ev_ais | (chg_ais & {N_CH{!status_rd}}); // RULE9
		end
	end

	// Open-drain request: level is always low, only the enable moves
	always_ff @(posedge i_ref_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			o_irq_n_out <= 1'b0; // RULE10
			o_irq_n_oe <= 1'b0;
		end else begin
			o_irq_n_out <= 1'b0; // RULE10
			o_irq_n_oe <= glb.irq_en && // RULE7 RULE22
				|((chg_los & ~mask_los) | (chg_ais & ~mask_ais)); // RULE6 RULE8
		end
	end

	// Termination select, from pins in hardware mode
	e1ram_term_s term_now;
	assign term_now = term_decode(hw_mode ? term_pin : glb.term_sel);

	always_ff @(posedge i_ref_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			o_term_tx_120 <= 1'b0;
			o_term_rx_on <= 1'b0;
			o_term_rx_120 <= 1'b0;
		end else begin
			o_term_tx_120 <= term_now.tx_120; // RULE3
			o_term_rx_on <= term_now.rx_on; // RULE3
			o_term_rx_120 <= term_now.rx_120; // RULE3
		end
	end

	// Per-channel receive logic
	genvar c;
	generate
		for (c = 0; c < N_CH; c++) begin : g_ch // RULE1
			logic a_prev;
			logic b_prev;
			logic edge_a;
			logic edge_b;
			logic [NCO_W-1:0] acc;
			logic [NCO_W:0] sum;
			logic tick;
			logic half;
			logic mark_pend;
			logic mark_neg;
			logic bit_now;
			logic neg_now;
			logic last_neg;
			logic violation;
			logic ami;
			logic etsi;
			logic [3:0] dly;
			logic [3:0] ndly;
			logic [11:0] below_run;
			logic [31:0] hist;
			logic [4:0] zero_run;
			logic [5:0] gap;
			logic [5:0] good_run;
			logic good_now;
			logic [7:0] half_cnt;
			logic second;
			logic [2:0] cur_z;
			logic [2:0] prev_z;
			logic [2:0] cur_with;
			logic [3:0] total_z;

			assign edge_a = line_a[c] & ~a_prev;
			assign edge_b = line_b[c] & ~b_prev;
			assign sum = {1'b0, acc} + {1'b0, NCO_INC};
			assign ami = hw_mode ? code_pin[c] : reg_ami[c]; // RULE2
			assign etsi = !hw_mode && reg_etsi[c]; // RULE15 RULE20
			assign bit_now = mark_pend | edge_a | edge_b;
			assign neg_now = (mark_pend & mark_neg) | edge_b;
			assign violation = !ami && bit_now && (neg_now == last_neg);

			always_ff @(posedge i_ref_clk or negedge i_rstn) begin
				if (!i_rstn) begin
					a_prev <= 1'b0;
					b_prev <= 1'b0;
				end else begin
					a_prev <= line_a[c];
					b_prev <= line_b[c];
				end
			end

			// Bit clock: pulses pull phase, otherwise free-runs on reference
			always_ff @(posedge i_ref_clk or negedge i_rstn) begin
				if (!i_rstn) begin
					acc <= '0;
					tick <= 1'b0;
					half <= 1'b0;
					o_rx_clk[c] <= 1'b0;
				end else begin
					if (edge_a || edge_b) begin
						acc <= NCO_ON_PULSE;
					end else begin
						acc <= sum[NCO_W-1:0]; // RULE4 RULE21
					end
					tick <= sum[NCO_W] && !(edge_a || edge_b);
					half <= !acc[NCO_W-1] && sum[NCO_W-1] && !sum[NCO_W];
					// From acc, so clock edges meet the data update
					o_rx_clk[c] <= !acc[NCO_W-1]; // RULE4
				end
			end

			// Pulse seen in the current bit period
			always_ff @(posedge i_ref_clk or negedge i_rstn) begin
				if (!i_rstn) begin
					mark_pend <= 1'b0;
					mark_neg <= 1'b0;
				end else if (edge_a || edge_b) begin
					mark_pend <= 1'b1;
					mark_neg <= edge_b;
				end else if (tick) begin
					mark_pend <= 1'b0;
				end
			end

			// Line decode through a four-bit delay so B00V can be removed
			always_ff @(posedge i_ref_clk or negedge i_rstn) begin
				if (!i_rstn) begin
					dly <= '0;
					ndly <= '0;
					last_neg <= 1'b1;
				end else if (tick) begin
					if (violation) begin
						dly <= {1'b0, dly[1:0], 1'b0}; // RULE2
					end else begin
						dly <= {dly[2:0], bit_now}; // RULE2
					end
					ndly <= {ndly[2:0], neg_now};
					if (bit_now) begin
						last_neg <= neg_now;
					end
				end
			end

			// Output edge chosen by the clock invert bit
			always_ff @(posedge i_ref_clk or negedge i_rstn) begin
				if (!i_rstn) begin
					o_rx_pos_data[c] <= 1'b0;
					o_rx_neg_data[c] <= 1'b0;
				end else if (glb.clk_inv ? half : tick) begin // RULE5
					o_rx_pos_data[c] <= dly[3];
					o_rx_neg_data[c] <= ndly[3];
				end
			end

			// Loss of signal: low-level run and recovery window
			assign good_now = above[c] && // RULE21
				count_ones({hist[30:0], bit_now}) >= LOS_WIN_ONES && gap == '0;

			always_ff @(posedge i_ref_clk or negedge i_rstn) begin
				if (!i_rstn) begin
					below_run <= '0;
					hist <= '0;
					zero_run <= '0;
					gap <= '0;
					good_run <= '0;
				end else if (tick) begin
					if (!below[c]) begin // RULE21
						below_run <= '0;
					end else if (below_run != LOS_ETSI_SET) begin
						below_run <= below_run + 12'h001;
					end
					hist <= {hist[30:0], bit_now};
					if (bit_now) begin
						zero_run <= '0;
					end else if (zero_run != LOS_ZERO_LIMIT) begin
						zero_run <= zero_run + 5'h01;
					end
					if (!bit_now && zero_run + 5'h01 >= LOS_ZERO_LIMIT) begin
						gap <= LOS_WIN_LEN; // RULE12
					end else if (gap != '0) begin
						gap <= gap - 6'h01;
					end
					if (!good_now) begin
						good_run <= '0;
					end else if (good_run != LOS_ETSI_GOOD) begin
						good_run <= good_run + 6'h01;
					end
				end
			end

			always_ff @(posedge i_ref_clk or negedge i_rstn) begin
				if (!i_rstn) begin
					o_rx_signal_loss[c] <= 1'b0;
				end else if (tick) begin
					if (!o_rx_signal_loss[c]) begin
						if (below[c] && below_run + 12'h001 >=
							(etsi ? LOS_ETSI_SET : LOS_G775_SET)) begin
							o_rx_signal_loss[c] <= 1'b1; // RULE11 RULE13
						end
					end else if (etsi) begin
						if (good_now && good_run + 6'h01 >= LOS_ETSI_GOOD) begin
							o_rx_signal_loss[c] <= 1'b0; // RULE14
						end
					end else if (good_now) begin
						o_rx_signal_loss[c] <= 1'b0; // RULE12
					end
				end
			end

			// All-ones: zeros counted per 256-bit half window
			assign cur_with = (!bit_now && cur_z != AIS_ZERO_MIN) ?
				cur_z + 3'h1 : cur_z;
			assign total_z = {1'b0, prev_z} + {1'b0, cur_with};

			always_ff @(posedge i_ref_clk or negedge i_rstn) begin
				if (!i_rstn) begin
					half_cnt <= '0;
					second <= 1'b0;
					cur_z <= '0;
					prev_z <= AIS_ZERO_MIN;
					o_all_ones_alarm[c] <= 1'b0;
				end else if (tick) begin
					half_cnt <= half_cnt + 8'h01;
					if (half_cnt == AIS_HALF_LAST) begin
						second <= !second;
						prev_z <= cur_with;
						cur_z <= '0;
						if (etsi) begin
							o_all_ones_alarm[c] <= // RULE19
								total_z < {1'b0, AIS_ZERO_MIN};
						end else if (second) begin
							o_all_ones_alarm[c] <= // RULE17 RULE18
								total_z < {1'b0, AIS_ZERO_MIN};
						end
					end else begin
						cur_z <= cur_with;
					end
				end
			end

			// Change events feed the status latches
			logic los_prev;
			logic ais_prev;

			always_ff @(posedge i_ref_clk or negedge i_rstn) begin
				if (!i_rstn) begin
					los_prev <= 1'b0;
					ais_prev <= 1'b0;
				end else begin
					los_prev <= o_rx_signal_loss[c];
					ais_prev <= o_all_ones_alarm[c];
				end
			end

			assign ev_los[c] = o_rx_signal_loss[c] ^ los_prev; // RULE8
			assign ev_ais[c] = o_all_ones_alarm[c] ^ ais_prev; // RULE8
		end
	endgenerate
endmodule

// ==== verification/e1ram_properties.sv ====
// Concurrent checks on the E1 receive alarm block's ports.
// Assumes one reference clock domain and shadows of host writes.
`timescale 1ns/1ns
module e1ram_properties import e1ram_pkg::*; #(
	parameter int N_CH = CH_COUNT
) (
	input wire logic i_ref_clk,
	input wire logic i_rstn,
	input wire logic [N_CH-1:0] i_below_low,
	input wire logic [ADDR_W-1:0] i_addr,
	input wire logic [DATA_W-1:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	input wire logic [DATA_W-1:0] o_rdata,
	input wire logic [N_CH-1:0] o_rx_clk,
	input wire logic [N_CH-1:0] o_rx_pos_data,
	input wire logic [N_CH-1:0] o_rx_neg_data,
	input wire logic [N_CH-1:0] o_rx_signal_loss,
	input wire logic [N_CH-1:0] o_all_ones_alarm,
	input wire logic o_irq_n_out,
	input wire logic o_irq_n_oe,
	input wire logic o_term_tx_120,
	input wire logic o_term_rx_on,
	input wire logic o_term_rx_120
);
	default clocking cb @(posedge i_ref_clk);
	endclocking
	default disable iff (!i_rstn);
	logic global_irq_enable;
	logic inv;
	logic mask0;
	logic [7:0] below_cnt;
	// Shadow of the host-written enable, invert and loss mask
	always_ff @(posedge i_ref_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			global_irq_enable <= 1'b0;
			inv <= 1'b0;
		end else if (i_wr && i_addr == OFS_GLOBAL) begin
			global_irq_enable <= i_wdata[GLB_IRQ_EN_BIT];
			inv <= i_wdata[GLB_CLK_INV_BIT];
		end
	end
	always_ff @(posedge i_ref_clk or negedge i_rstn) begin
		if (!i_rstn)
			mask0 <= 1'b0;
		else if (i_wr && i_addr == OFS_CH_CFG)
			mask0 <= i_wdata[CFG_LOS_MASK_LSB];
	end
	// Consecutive cycles of low level on channel 0, saturating
	always_ff @(posedge i_ref_clk or negedge i_rstn) begin
		if (!i_rstn)
			below_cnt <= 8'h00;
		else if (!i_below_low[0])
			below_cnt <= 8'h00;
		else if (below_cnt != 8'hFF)
			below_cnt <= below_cnt + 8'h01;
	end
	sequence s_quiet;
		($stable(o_rx_signal_loss) && $stable(o_all_ones_alarm)) [*3];
	endsequence
	sequence s_quiet_read;
		s_quiet ##0 (i_rd && i_addr == OFS_STATUS) ##1 s_quiet;
	endsequence
	AST_IRQ_NEVER_HIGH: assert property (o_irq_n_out == 1'b0)
		else $error("interrupt pin driven high");
	AST_IRQ_GATED: assert property (o_irq_n_oe |-> $past(global_irq_enable))
		else $error("interrupt without global enable");
	AST_IRQ_ON_CHANGE: assert property (
		($changed(o_rx_signal_loss[0]) && global_irq_enable && !mask0) |->
		##[1:3] o_irq_n_oe)
		else $error("unmasked loss change raised no interrupt");
	AST_IRQ_RELEASE: assert property (s_quiet_read |=> !o_irq_n_oe)
		else $error("interrupt held after status read");
	AST_DATA_EDGE: assert property (
		$changed({o_rx_neg_data[0], o_rx_pos_data[0]}) |->
		($past(inv) ? $fell(o_rx_clk[0]) : $rose(o_rx_clk[0])))
		else $error("data changed on wrong clock edge");
	AST_TERM_DECODE: assert property (o_term_rx_120 |-> (o_term_rx_on && o_term_tx_120))
		else $error("termination decode inconsistent");
	AST_LOS_SET_HOLD: assert property ($rose(o_rx_signal_loss[0]) |-> below_cnt >= 8'd140)
		else $error("loss declared too early");
	AST_RDATA_IDLE: assert property (!i_rd |=> o_rdata == '0)
		else $error("read data outside read answer");
	AST_UNMAPPED: assert property ((i_rd && i_addr > OFS_STATUS) |=> o_rdata == '0)
		else $error("unmapped read not zero");
endmodule

bind e1ram_top e1ram_properties #(
	.N_CH(N_CH)
) u_props (
	.i_ref_clk(i_ref_clk),
	.i_rstn(i_rstn),
	.i_below_low(i_below_low),
	.i_addr(i_addr),
	.i_wdata(i_wdata),
	.i_wr(i_wr),
	.i_rd(i_rd),
	.o_rdata(o_rdata),
	.o_rx_clk(o_rx_clk),
	.o_rx_pos_data(o_rx_pos_data),
	.o_rx_neg_data(o_rx_neg_data),
	.o_rx_signal_loss(o_rx_signal_loss),
	.o_all_ones_alarm(o_all_ones_alarm),
	.o_irq_n_out(o_irq_n_out),
	.o_irq_n_oe(o_irq_n_oe),
	.o_term_tx_120(o_term_tx_120),
	.o_term_rx_on(o_term_rx_on),
	.o_term_rx_120(o_term_rx_120)
);

// ==== verification/e1ram_line_model.sv ====
// Line and slicer model: AMI marks at five reference cycles per bit.
// Assumes per-channel control of signal loss and ones density.
`timescale 1ns/1ns
module e1ram_line_model (
	input wire logic i_ref_clk,
	input wire logic i_rstn,
	input wire logic [7:0] i_lost,
	input wire logic [7:0] i_dense,
	output logic [7:0] o_line_a,
	output logic [7:0] o_line_b,
	output logic [7:0] o_above_high,
	output logic [7:0] o_below_low
);
	logic [2:0] ph;
	logic odd;
	logic [7:0] pol;
	logic [7:0] mark;
	// All ones when dense, else every other bit a mark
	assign mark = ~i_lost & (i_dense | {8{odd}});
	// Slicer levels follow loss directly
	assign o_above_high = ~i_lost;
	assign o_below_low = i_lost;
	always_ff @(posedge i_ref_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			ph <= 3'd0;
			odd <= 1'b0;
			pol <= 8'h00;
			o_line_a <= 8'h00;
			o_line_b <= 8'h00;
		end else begin
			ph <= (ph == 3'd4) ? 3'd0 : ph + 3'd1;
			if (ph == 3'd0) begin
				odd <= !odd;
				pol <= pol ^ mark;
				o_line_a <= mark & ~pol;
				o_line_b <= mark & pol;
			end else if (ph == 3'd2) begin
				o_line_a <= 8'h00;
				o_line_b <= 8'h00;
			end
		end
	end
endmodule

// ==== verification/e1_receive_alarm_monitor_tb.sv ====
// Self-checking bench: register access, alarms, interrupt and clock.
// Assumes the line model on all eight channels and a 10 MHz clock.
`timescale 1ns/1ns
module e1_receive_alarm_monitor_tb;
	import e1ram_pkg::*;
	logic i_ref_clk = 1'b0;
	logic i_rstn = 1'b0;
	logic hw_mode = 1'b0;
	logic [1:0] term_sel = 2'b00;
	logic [7:0] lost = 8'h00;
	logic [7:0] dense = 8'h00;
	logic [7:0] addr = 8'h00;
	logic [31:0] wdata = 32'h0000_0000;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [7:0] line_a, line_b, above, below;
	logic [31:0] rdata;
	logic [7:0] rx_clk, pos, neg, loss, all_ones_alarm;
	logic irq_out, irq_oe, tx_120, rx_on, rx_120;
	int error_cnt = 0;
	int tests_run = 0;
	always #50 i_ref_clk = ~i_ref_clk;
	e1ram_line_model line (
		.i_ref_clk(i_ref_clk),
		.i_rstn(i_rstn),
		.i_lost(lost),
		.i_dense(dense),
		.o_line_a(line_a),
		.o_line_b(line_b),
		.o_above_high(above),
		.o_below_low(below)
	);
	e1ram_top dut (
		.i_ref_clk(i_ref_clk),
		.i_rstn(i_rstn),
		.i_hw_mode(hw_mode),
		.i_rx_line_a(line_a),
		.i_rx_line_b(line_b),
		.i_above_high(above),
		.i_below_low(below),
		.i_neg_data_or_code_select(8'h00),
		.i_termination_select(term_sel),
		.i_addr(addr),
		.i_wdata(wdata),
		.i_wr(wr),
		.i_rd(rd),
		.o_rdata(rdata),
		.o_rx_clk(rx_clk),
		.o_rx_pos_data(pos),
		.o_rx_neg_data(neg),
		.o_rx_signal_loss(loss),
		.o_all_ones_alarm(all_ones_alarm),
		.o_irq_n_out(irq_out),
		.o_irq_n_oe(irq_oe),
		.o_term_tx_120(tx_120),
		.o_term_rx_on(rx_on),
		.o_term_rx_120(rx_120)
	);
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			error_cnt++;
			$display("wrong value at %0t: got %h expected %h", $time, seen, exp);
		end
	endtask
	task end_sim;
		if (error_cnt == 0 && tests_run > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task wr_reg(input logic [7:0] a, input logic [31:0] d);
		@(posedge i_ref_clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge i_ref_clk);
		wr <= 1'b0;
	endtask
	task rd_reg(input logic [7:0] a, output logic [31:0] d);
		@(posedge i_ref_clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge i_ref_clk);
		rd <= 1'b0;
		#1 d = rdata;
	endtask
	task cyc(input int n);
		repeat (n) @(posedge i_ref_clk);
	endtask
	// Bounded wait for an alarm flag of one channel to reach a level
	task wait_flag(input logic is_ais, input int ch, input logic lvl,
		input int lim);
		for (int n = 0; n < lim && (is_ais ? all_ones_alarm[ch] : loss[ch]) !== lvl; n++)
			@(posedge i_ref_clk);
		chk(is_ais ? all_ones_alarm[ch] : loss[ch], lvl);
	endtask
	initial begin
		repeat (100000) @(posedge i_ref_clk);
		error_cnt++;
		end_sim();
	end
	initial begin
		logic [31:0] d;
		int cnt;
		logic p;
		cyc(8);
		i_rstn <= 1'b1;
		rd_reg(OFS_GLOBAL, d);
		chk(d, RST_GLOBAL);
		rd_reg(OFS_CH_CFG, d);
		chk(d, RST_CH_CFG);
		rd_reg(8'h40, d);
		chk(d, 32'h0000_0000);
		@(posedge i_ref_clk);
		hw_mode <= 1'b1;
		for (int k = 0; k < 4; k++) begin
			term_sel <= 2'(k);
			cyc(8);
			chk({tx_120, rx_on, rx_120}, {k[0], k[1], k[1] & k[0]});
		end
		hw_mode <= 1'b0;
		cyc(8);
		wr_reg(OFS_GLOBAL, 32'h0000_0009);
		wr_reg(OFS_ALARM, 32'hFFFF_FFFF);
		cyc(400);
		chk({tx_120, rx_on, rx_120}, 32'h0000_0002);
		rd_reg(OFS_ALARM, d);
		chk(d, 32'h0000_0000);
		rd_reg(OFS_STATUS, d);
		@(posedge i_ref_clk);
		lost <= 8'h01;
		wait_flag(0, 0, 1, 400);
		chk(loss, 8'h01);
		cyc(3);
		chk(irq_oe, 1'b1);
		cnt = 0;
		p = rx_clk[0];
		repeat (500) begin
			@(posedge i_ref_clk);
			#1;
			if (rx_clk[0] === 1'b1 && p === 1'b0)
				cnt++;
			p = rx_clk[0];
		end
		chk(cnt >= 100 && cnt <= 105, 1'b1);
		chk({pos[0], neg[0]}, 2'b00);
		rd_reg(OFS_STATUS, d);
		chk(d, 32'h0000_0001);
		cyc(3);
		chk(irq_oe, 1'b0);
		wr_reg(OFS_CH_CFG, 32'h0001_0000);
		lost <= 8'h00;
		wait_flag(0, 0, 0, 2000);
		chk(loss[0], 1'b0);
		cyc(4);
		chk(irq_oe, 1'b0);
		rd_reg(OFS_STATUS, d);
		chk(d, 32'h0000_0001);
		wr_reg(OFS_GLOBAL, 32'h0000_0000);
		wr_reg(OFS_CH_CFG, 32'h0000_0000);
		lost <= 8'h01;
		wait_flag(0, 0, 1, 400);
		cyc(4);
		chk(irq_oe, 1'b0);
		lost <= 8'h00;
		wait_flag(0, 0, 0, 2000);
		rd_reg(OFS_STATUS, d);
		wr_reg(OFS_GLOBAL, 32'h0000_0001);
		for (int e = 0; e < 2; e++) begin
			wr_reg(OFS_CH_CFG, e ? 32'h0000_0400 : 32'h0000_0000);
			dense <= 8'h04;
			wait_flag(1, 2, 1, 8000);
			chk(all_ones_alarm, 8'h04);
			chk(pos[2], 1'b1);
			cyc(3);
			chk(irq_oe, 1'b1);
			dense <= 8'h00;
			wait_flag(1, 2, 0, 8000);
			chk(all_ones_alarm[2], 1'b0);
			rd_reg(OFS_STATUS, d);
			chk(d, 32'h0000_0400);
		end
		wr_reg(OFS_CH_CFG, 32'h0000_0100);
		hw_mode <= 1'b1;
		cyc(8);
		lost <= 8'h01;
		wait_flag(0, 0, 1, 400);
		chk(loss[0], 1'b1);
		lost <= 8'h00;
		wait_flag(0, 0, 0, 2000);
		hw_mode <= 1'b0;
		cyc(8);
		lost <= 8'h01;
		cyc(2000);
		chk(loss[0], 1'b0);
		wait_flag(0, 0, 1, 12000);
		chk(loss[0], 1'b1);
		lost <= 8'h00;
		cyc(100);
		chk(loss[0], 1'b1);
		wait_flag(0, 0, 0, 2000);
		chk(loss[0], 1'b0);
		wr_reg(OFS_GLOBAL, 32'h0000_0003);
		cyc(300);
		end_sim();
	end
endmodule
